// *** rtl/fclk_consts.svh ***
/*
 * register offsets, select codes, reset values and counts of the
 * clock mode controller; assumes byte addressing on a 32-bit bus.
 */
`ifndef FCLK_CONSTS_SVH
`define FCLK_CONSTS_SVH

`define FCLK_OFF_CTRL      8'h00
`define FCLK_OFF_STATUS    8'h04
`define FCLK_OFF_FILT_UP   8'h08
`define FCLK_OFF_FILT_LO   8'h0C
`define FCLK_OFF_TRIM      8'h10

`define FCLK_CS_SCM        2'h0
`define FCLK_CS_FEI        2'h1
`define FCLK_CS_FBE        2'h2
`define FCLK_CS_FEE        2'h3

`define FCLK_RST_MULT      3'h0
`define FCLK_RST_DIV       3'h0
`define FCLK_RST_TRIM      8'h80
`define FCLK_RST_FILT      12'h200
`define FCLK_XTAL_COUNT    4096
`define FCLK_LATCH_CYC     2'h3

`endif

// *** rtl/fclk_loop.sv ***
/*
 * loop filter, lock detector and filter value register of the locked loop.
 * assumes count error and sample strobe come from a pulse counter on clk_i,
 * and that osc_static_i is already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fclk_consts.svh"

module fclk_loop #(
	parameter int LOCK_WIN     = 4,
	parameter int UNLOCK_WIN   = 16,
	parameter int LOCK_SAMPLES = 4
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               sample_i,
	input  wire logic signed [11:0] err_i,
	input  wire logic               closed_i,
	input  wire logic               locked_i,
	input  wire logic               off_i,
	input  wire logic               sw_ok_i,
	input  wire logic               wr_up_i,
	input  wire logic               wr_lo_i,
	input  wire logic        [7:0]  wdata_i,
	input  wire logic               osc_static_i,
	output logic             [11:0] filt_o,
	output logic                    lock_ok_o,
	output logic                    unlock_o,
	output logic                    osc_stable_o,
	output logic                    busy_o
);
	typedef struct packed {
		logic [11:0]        filt;
		logic [7:0]         low;
		logic [1:0]         busy;
		logic signed [13:0] acc;
		logic [1:0]         avg_n;
		logic [3:0]         lock_n;
		logic               in_unl;
		logic               stable;
	} fclk_loop_t;

	fclk_loop_t q;
	fclk_loop_t n;
	logic in_lock;
	logic in_unlock;

	assign in_lock   = (err_i <= 12'(LOCK_WIN)) && (err_i >= -12'(LOCK_WIN));
	assign in_unlock = (err_i <= 12'(UNLOCK_WIN)) && (err_i >= -12'(UNLOCK_WIN));

	// filter stepping, averaging and software load
	always_comb begin
		logic signed [13:0] sum;
		sum = q.acc + 14'(err_i);
		n = q;
		if (q.busy != 2'h0) begin
			n.busy = q.busy - 2'h1;
		end
		if (wr_lo_i && sw_ok_i) begin
			n.low = wdata_i;
		end
		// a busy latch sequence shields the value from a second write
		if (wr_up_i && sw_ok_i && (q.busy == 2'h0)) begin
			n.filt = {wdata_i[3:0], q.low};
			n.busy = `FCLK_LATCH_CYC;
		end
		if (sample_i && closed_i) begin
			if (locked_i) begin
				n.avg_n = q.avg_n + 2'h1;
				n.acc   = sum;
				if (q.avg_n == 2'h3) begin
					n.filt = 12'(14'(q.filt) - (sum >>> 2));
					n.acc  = 14'h0;
				end
			end else begin
				n.filt  = 12'(14'(q.filt) - 14'(err_i));
				n.avg_n = 2'h0;
				n.acc   = 14'h0;
			end
			// lock needs a run of in-window samples
			n.lock_n = in_lock ? ((q.lock_n == 4'(LOCK_SAMPLES)) ? q.lock_n
				: q.lock_n + 4'h1) : 4'h0;
		end
		if (!closed_i) begin
			n.lock_n = 4'h0;
			n.avg_n  = 2'h0;
			n.acc    = 14'h0;
		end
		if (sample_i) begin
			n.in_unl = in_unlock;
			n.stable = in_unlock && q.in_unl && !osc_static_i;
		end
		if (off_i) begin
			n.stable = 1'b0;
			n.in_unl = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{filt: `FCLK_RST_FILT, low: 8'h00, busy: 2'h0, acc: 14'h0,
				avg_n: 2'h0, lock_n: 4'h0, in_unl: 1'b0, stable: 1'b0};
		end else begin
			q <= n;
		end
	end

	assign filt_o       = q.filt;
	assign lock_ok_o    = (q.lock_n == 4'(LOCK_SAMPLES));
	assign unlock_o     = sample_i && !in_unlock;
	assign osc_stable_o = q.stable;
	assign busy_o       = (q.busy != 2'h0);

	filt_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_up_i && !sw_ok_i && !(sample_i && closed_i) |=> $stable(filt_o))
		else $error("filter changed by write outside self-clocked mode");
	latch_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_o && wr_up_i && !sample_i |=> filt_o == $past(filt_o))
		else $error("filter written during latch sequence");
	stable_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		off_i |=> !osc_stable_o)
		else $error("oscillator stable flag survived off state");

endmodule
`default_nettype wire

// *** rtl/fclk_mode_ctrl.sv ***
/*
 * clock mode controller: off, self-clocked, internal and external locked
 * and bypass modes, filter and trim registers behind an avalon-mm slave.
 * assumes stop, debug and loop error come from clk_i logic; reference
 * status, loss, static and crystal pins are asynchronous.
 */
// Notes on behaviour
// - filter writable only when selection is self-clocked
// - upper write ignored while latch sequence busy
// - trim lengthens period as value grows
// - trim survives every reset except power-on
// - stop halts clocks unless debug is enabled
// - stop-enable keeps generators, gates chip feed
// - interrupt wake keeps settings, internal ref first
// - bypass wake holds output until ref stable
// - reset wake loads defaults, self-clocked
// - crystal needs 4096 clocks before use
// - self-clocked entry conditions
// - self-clocked: loop open, output oscillator divided
// - filter write sets oscillator frequency
// - leaving loop keeps frequency, unlocked external halves (code: only until its first lock after entry)
// - off exit resumes previous oscillator frequency
// - off exit with X1 closes loop when stable
// - internal loop on select 01 or wake
// - internal loop steers toward multiplier target
// - unlocked while error outside window
// - locked after enough in-window samples
// - locked filter updates on four-sample average
// - status encodes the four clock modes
// - stable after two good samples, cleared off
`timescale 1ns/1ps
`default_nettype none
`include "fclk_consts.svh"

module fclk_mode_ctrl #(
	parameter int XTAL_COUNT   = `FCLK_XTAL_COUNT,
	parameter int LOCK_WIN     = 4,
	parameter int UNLOCK_WIN   = 16,
	parameter int LOCK_SAMPLES = 4
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               por_i,
	input  wire logic        [7:0]  address_i,
	input  wire logic               read_i,
	input  wire logic               write_i,
	input  wire logic        [31:0] writedata_i,
	output logic             [31:0] readdata_o,
	output logic                    waitrequest_o,
	input  wire logic               stop_i,
	input  wire logic               debug_en_i,
	input  wire logic               ext_ref_ok_i,
	input  wire logic               clock_loss_i,
	input  wire logic               osc_static_i,
	input  wire logic               xtal_clk_i,
	input  wire logic               sample_i,
	input  wire logic signed [11:0] count_err_i,
	output logic             [1:0]  clock_mode_status_o,
	output logic             [11:0] filter_value_o,
	output logic             [7:0]  trim_o,
	output logic             [2:0]  mult_factor_o,
	output logic             [2:0]  out_div_o,
	output logic                    out_half_o,
	output logic                    out_clk_en_o,
	output logic                    osc_run_o,
	output logic                    int_ref_sel_o,
	output logic                    loop_closed_o
);
	typedef struct packed {
		fclk_pkg::fclk_state_t st;
		logic [1:0]  cs;
		logic [2:0]  mult;
		logic [2:0]  div;
		logic        osen;
		logic        xtal;
		logic        pend;
		logic        fee_first;
		logic        ack;
		logic [31:0] rdata;
		logic [3:0]  s1;
		logic [3:0]  s2;
		logic        x3;
		logic [12:0] xcnt;
	} fclk_ctrl_t;

	fclk_ctrl_t q;
	fclk_ctrl_t n;
	logic [7:0] trim_ff;
	logic       req;
	logic       wr;
	logic       ext_ok;
	logic       loss;
	logic       xdone;
	logic       ext_rdy;
	logic       off;
	logic       self_clocked_mode;
	logic       internal_locked_mode;
	logic       fee;
	logic       fbe;
	logic       locked;
	logic       closed;
	logic       feed_gate;
	logic [11:0] filt;
	logic       lock_ok;
	logic       unlock;
	logic       osc_stable;
	logic       busy;

	// synchronised pins: s1 feeds only s2
	assign ext_ok  = q.s2[0];
	assign loss    = q.s2[1];
	assign xdone   = (q.xcnt == 13'(XTAL_COUNT));
	assign ext_rdy = ext_ok && (xdone || !q.xtal);
	assign off     = (q.st == fclk_pkg::ST_OFF);
	assign self_clocked_mode     = (q.st == fclk_pkg::ST_SCM);
	assign internal_locked_mode     = (q.st == fclk_pkg::ST_FEI_UNL) || (q.st == fclk_pkg::ST_FEI_LCK);
	assign fee     = (q.st == fclk_pkg::ST_FEE_UNL) || (q.st == fclk_pkg::ST_FEE_LCK);
	assign fbe     = (q.st == fclk_pkg::ST_FBE);
	assign locked  = (q.st == fclk_pkg::ST_FEI_LCK) || (q.st == fclk_pkg::ST_FEE_LCK);
	assign closed  = internal_locked_mode || fee;
	assign req     = read_i || write_i;
	assign wr      = write_i && q.ack;

	// chip feed is cut in stop when generators are kept alive
	assign feed_gate = stop_i && !debug_en_i && q.osen;

	fclk_loop #(
		.LOCK_WIN     (LOCK_WIN),
		.UNLOCK_WIN   (UNLOCK_WIN),
		.LOCK_SAMPLES (LOCK_SAMPLES)
	) u_loop (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.sample_i     (sample_i),
		.err_i        (count_err_i),
		.closed_i     (closed),
		.locked_i     (locked),
		.off_i        (off),
		.sw_ok_i      (self_clocked_mode && (q.cs == `FCLK_CS_SCM)),
		.wr_up_i      (wr && (address_i == `FCLK_OFF_FILT_UP)),
		.wr_lo_i      (wr && (address_i == `FCLK_OFF_FILT_LO)),
		.wdata_i      (writedata_i[7:0]),
		.osc_static_i (q.s2[2]),
		.filt_o       (filt),
		.lock_ok_o    (lock_ok),
		.unlock_o     (unlock),
		.osc_stable_o (osc_stable),
		.busy_o       (busy)
	);

	// bus slave, mode sequencing and crystal qualification
	always_comb begin
		logic [1:0] cs_new;
		cs_new  = writedata_i[1:0];
		n       = q;
		n.ack   = req && !q.ack;
		n.s1    = {xtal_clk_i, osc_static_i, clock_loss_i, ext_ref_ok_i};
		n.s2    = q.s1;
		n.x3    = q.s2[3];
		if (req && !q.ack) begin
			unique case (address_i)
				`FCLK_OFF_CTRL:    n.rdata = {22'h0, q.xtal, q.osen, q.div, q.mult, q.cs};
				`FCLK_OFF_STATUS:  n.rdata = {25'h0, busy, loss, ext_ok, osc_stable,
					locked, clock_mode_status_o};
				`FCLK_OFF_FILT_UP: n.rdata = {28'h0, filt[11:8]};
				`FCLK_OFF_FILT_LO: n.rdata = {24'h0, filt[7:0]};
				`FCLK_OFF_TRIM:    n.rdata = {24'h0, trim_ff};
				default:           n.rdata = 32'h0000_0000;
			endcase
		end
		// crystal edges counted until qualified
		if (!q.xtal || (off && !q.osen)) begin
			n.xcnt = 13'h0;
		end else if (q.s2[3] && !q.x3 && !xdone) begin
			n.xcnt = q.xcnt + 13'h1;
		end
		unique case (q.st)
			fclk_pkg::ST_OFF: begin
				if (!stop_i) begin
					if (q.cs == `FCLK_CS_FBE) begin
						n.st = fclk_pkg::ST_FBE;
					end else begin
						n.st   = fclk_pkg::ST_SCM;
						n.pend = q.cs[0];
					end
				end
			end
			fclk_pkg::ST_SCM: begin
				if (q.pend && osc_stable) begin
					n.pend      = 1'b0;
					n.fee_first = q.cs[1];
					n.st = q.cs[1] ? fclk_pkg::ST_FEE_UNL : fclk_pkg::ST_FEI_UNL;
				end
			end
			fclk_pkg::ST_FEI_UNL: begin
				if (lock_ok) begin
					n.st = fclk_pkg::ST_FEI_LCK;
				end
			end
			fclk_pkg::ST_FEI_LCK: begin
				if (unlock) begin
					n.st = fclk_pkg::ST_FEI_UNL;
				end
			end
			fclk_pkg::ST_FEE_UNL: begin
				if (lock_ok) begin
					n.st        = fclk_pkg::ST_FEE_LCK;
					n.fee_first = 1'b0;
				end
			end
			fclk_pkg::ST_FEE_LCK: begin
				if (unlock) begin
					n.st = fclk_pkg::ST_FEE_UNL;
				end
			end
			fclk_pkg::ST_FBE: begin
			end
		endcase
		// lost reference falls back; lost oscillator keeps bypass
		if ((fee || fbe) && loss) begin
			if (ext_ok && fee) begin
				n.st = fclk_pkg::ST_FBE;
				n.cs = `FCLK_CS_FBE;
			end else if (!ext_ok) begin
				n.st = fclk_pkg::ST_SCM;
				n.cs = `FCLK_CS_SCM;
			end
		end
		if (wr && (address_i == `FCLK_OFF_CTRL)) begin
			n.cs   = cs_new;
			n.mult = writedata_i[4:2];
			n.div  = writedata_i[7:5];
			n.osen = writedata_i[8];
			n.xtal = writedata_i[9];
			n.pend = 1'b0;
			if (cs_new == `FCLK_CS_SCM && q.cs[0]) begin
				n.st = fclk_pkg::ST_SCM;
			end else if (cs_new == `FCLK_CS_FEI && q.cs != `FCLK_CS_FEI) begin
				n.st = fclk_pkg::ST_FEI_UNL;
			end else if (cs_new == `FCLK_CS_FEE && q.cs != `FCLK_CS_FEE && ext_rdy) begin
				n.st        = fclk_pkg::ST_FEE_UNL;
				n.fee_first = 1'b1;
			end else if (cs_new == `FCLK_CS_FBE && self_clocked_mode && ext_rdy) begin
				n.st = fclk_pkg::ST_FBE;
			end
		end
		// stop without debug or stop-enable shuts everything down
		if (stop_i && !debug_en_i && !q.osen) begin
			n.st   = fclk_pkg::ST_OFF;
			n.pend = 1'b0;
		end
	end

	// reset exit always restarts self-clocked with default settings
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '{st: fclk_pkg::ST_SCM, cs: `FCLK_CS_SCM, mult: `FCLK_RST_MULT,
				div: `FCLK_RST_DIV, osen: 1'b0, xtal: 1'b0, pend: 1'b0,
				fee_first: 1'b0, ack: 1'b0, rdata: 32'h0000_0000, s1: 4'h0,
				s2: 4'h0, x3: 1'b0, xcnt: 13'h0};
		end else begin
			q <= n;
		end
	end

	// trim sits outside the mcu reset so a factory value is not lost
	always_ff @(posedge clk_i or posedge por_i) begin
		if (por_i) begin
			trim_ff <= `FCLK_RST_TRIM;
		end else if (wr && (address_i == `FCLK_OFF_TRIM)) begin
			trim_ff <= writedata_i[7:0];
		end
	end

	// mode status and generator controls
	always_comb begin
		unique case (1'b1)
			internal_locked_mode:     clock_mode_status_o = `FCLK_CS_FEI;
			fee:     clock_mode_status_o = `FCLK_CS_FEE;
			fbe:     clock_mode_status_o = `FCLK_CS_FBE;
			default: clock_mode_status_o = `FCLK_CS_SCM;
		endcase
	end

	assign readdata_o     = q.rdata;
	assign waitrequest_o  = req && !q.ack;
	assign filter_value_o = filt;
	assign trim_o         = trim_ff;
	assign mult_factor_o  = q.mult;
	assign out_div_o      = q.div;
	assign out_half_o     = fee && q.fee_first && !locked;
	assign osc_run_o      = !off && !fbe;
	assign int_ref_sel_o  = internal_locked_mode || (fee && !ext_rdy);
	assign loop_closed_o  = closed;
	assign out_clk_en_o   = !off && !feed_gate && !(fbe && !ext_rdy);

	stop_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_i && !debug_en_i && !q.osen |=> off && !out_clk_en_o && !osc_run_o)
		else $error("clocks running in stop without debug");
	feed_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_i && !debug_en_i && q.osen |-> !out_clk_en_o)
		else $error("chip feed active in stop with stop-enable");
	fbe_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		fbe && !ext_ok |-> !out_clk_en_o)
		else $error("bypass output enabled before reference stable");
	status_enc_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clock_mode_status_o == 2'h1) == internal_locked_mode && (clock_mode_status_o == 2'h3) == fee)
		else $error("mode status mismatch");
	xtal_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
		fee && q.xtal && !xdone |-> int_ref_sel_o)
		else $error("crystal used before qualification");
	back_scm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && address_i == 8'h00 && writedata_i[1:0] == 2'h0 && q.cs[0]
		&& !stop_i |=> self_clocked_mode)
		else $error("self-clocked not entered on select write");
	close_loop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		self_clocked_mode && q.pend && osc_stable && !stop_i && !wr |=> closed)
		else $error("loop not closed after oscillator stable");
	wait_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !q.ack |=> !waitrequest_o || !req)
		else $error("bus answer late");

	fei_lock_c: cover property (@(posedge clk_i) disable iff (rst_i)
		q.st == fclk_pkg::ST_FEI_LCK);
	off_wake_c: cover property (@(posedge clk_i) disable iff (rst_i)
		off ##1 self_clocked_mode ##[1:200] closed);
	fbe_run_c: cover property (@(posedge clk_i) disable iff (rst_i)
		fbe && out_clk_en_o);

endmodule
`default_nettype wire

// *** rtl/fclk_pkg.sv ***
/*
 * types of the clock mode controller; constants live in the header.
 */
package fclk_pkg;

	// one-hot modes of the generator
	typedef enum logic [6:0] {
		ST_OFF     = 7'b000_0001,
		ST_SCM     = 7'b000_0010,
		ST_FEI_UNL = 7'b000_0100,
		ST_FEI_LCK = 7'b000_1000,
		ST_FEE_UNL = 7'b001_0000,
		ST_FEE_LCK = 7'b010_0000,
		ST_FBE     = 7'b100_0000
	} fclk_state_t;

endpackage

// *** verification/fclk_ref_model.sv ***
/*
 * reference side model: crystal pin, reference status, static flag and
 * pulse counter samples. assumes calls come just after a clk_i edge.
 */
`timescale 1ns/1ps
`default_nettype none

module fclk_ref_model (
	input  wire logic          clk_i,
	output logic               xtal_clk_o,
	output logic               ext_ref_ok_o,
	output logic               clock_loss_o,
	output logic               osc_static_o,
	output logic               sample_o,
	output logic signed [11:0] count_err_o
);
	// crystal runs free, unrelated in phase to clk_i
	initial begin
		xtal_clk_o = 1'b0;
		ext_ref_ok_o = 1'b0;
		clock_loss_o = 1'b0;
		osc_static_o = 1'b0;
		sample_o = 1'b0;
		count_err_o = 12'h5a5;
		forever #60 xtal_clk_o = ~xtal_clk_o;
	end

	// oscillator reported static by its monitor
	task automatic set_static(input logic st);
		osc_static_o <= st;
	endtask

	// one comparison; stale error is inverted, so a zero sample leaves -1 behind
	task automatic send_sample(input logic signed [11:0] e);
		sample_o <= 1'b1;
		count_err_o <= e;
		@(posedge clk_i);
		sample_o <= 1'b0;
		count_err_o <= ~e;
		@(posedge clk_i);
	endtask

	// reference status as the monitor would report it
	task automatic set_ref(input logic ok, input logic loss);
		ext_ref_ok_o <= ok;
		clock_loss_o <= loss;
	endtask
endmodule

`default_nettype wire

// *** verification/tb_freq_locked_clock_mode_ctrl.sv ***
/*
 * self-checking bench of the clock mode controller: bus, loop, stop, reset.
 * assumes the reference model file is compiled with it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_freq_locked_clock_mode_ctrl;
	logic               clk_i;
	logic               rst_i;
	logic               por_i;
	logic        [7:0]  address_i;
	logic               read_i;
	logic               write_i;
	logic        [31:0] writedata_i;
	logic        [31:0] readdata_o;
	logic               waitrequest_o;
	logic               stop_i;
	logic               debug_en_i;
	logic               ext_ref_ok_i;
	logic               clock_loss_i;
	logic               osc_static_i;
	logic               xtal_clk_i;
	logic               sample_i;
	logic signed [11:0] count_err_i;
	logic        [1:0]  clock_mode_status_o;
	logic        [11:0] filter_value_o;
	logic        [7:0]  trim_o;
	logic        [2:0]  mult_factor_o;
	logic        [2:0]  out_div_o;
	logic               out_half_o;
	logic               out_clk_en_o;
	logic               osc_run_o;
	logic               int_ref_sel_o;
	logic               loop_closed_o;
	int                 err_count;
	int                 n_checks;
	int                 cyc;

	fclk_mode_ctrl #(.XTAL_COUNT(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
		.address_i(address_i), .read_i(read_i), .write_i(write_i),
		.writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.stop_i(stop_i), .debug_en_i(debug_en_i), .ext_ref_ok_i(ext_ref_ok_i),
		.clock_loss_i(clock_loss_i), .osc_static_i(osc_static_i), .xtal_clk_i(xtal_clk_i),
		.sample_i(sample_i), .count_err_i(count_err_i),
		.clock_mode_status_o(clock_mode_status_o), .filter_value_o(filter_value_o),
		.trim_o(trim_o), .mult_factor_o(mult_factor_o), .out_div_o(out_div_o),
		.out_half_o(out_half_o), .out_clk_en_o(out_clk_en_o), .osc_run_o(osc_run_o),
		.int_ref_sel_o(int_ref_sel_o), .loop_closed_o(loop_closed_o));

	fclk_ref_model partner_u (.clk_i(clk_i), .xtal_clk_o(xtal_clk_i),
		.ext_ref_ok_o(ext_ref_ok_i), .clock_loss_o(clock_loss_i),
		.osc_static_o(osc_static_i), .sample_o(sample_i), .count_err_o(count_err_i));

	// 20 MHz system clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// cut a hang short; the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a gap of one edge keeps back-to-back requests from clashing;
	// the closing edge lets the write land before callers look at outputs
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		if (read_i === 1'b1 || write_i === 1'b1) @(posedge clk_i);
		address_i <= a;
		writedata_i <= d;
		write_i <= 1'b1;
		do @(posedge clk_i); while (waitrequest_o !== 1'b0);
		write_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		if (read_i === 1'b1 || write_i === 1'b1) @(posedge clk_i);
		address_i <= a;
		read_i <= 1'b1;
		do @(posedge clk_i); while (waitrequest_o !== 1'b0);
		d = readdata_o;
		read_i <= 1'b0;
	endtask

	// reset values and an unmapped address
	task automatic t_reset_values();
		logic [31:0] d;
		bus_rd(8'h08, d);
		check(d, 32'h0000_0002);
		bus_rd(8'h0C, d);
		check(d, 32'h0000_0000);
		bus_rd(8'h10, d);
		check(d, 32'h0000_0080);
		bus_rd(8'h14, d);
		check(d, 32'h0000_0000);
		check(clock_mode_status_o, 2'h0);
		check(loop_closed_o, 1'b0);
		check(osc_run_o, 1'b1);
	endtask

	// staged lower byte, upper write, then a write into the busy window
	task automatic t_filter_write();
		logic [31:0] d;
		bus_wr(8'h0C, 32'h0000_0034);
		bus_wr(8'h08, 32'h0000_0005);
		check(filter_value_o, 12'h534);
		bus_wr(8'h08, 32'h0000_0006);
		check(filter_value_o, 12'h534);
		repeat (5) @(posedge clk_i);
		bus_wr(8'h08, 32'h0000_0006);
		check(filter_value_o, 12'h634);
		bus_rd(8'h0C, d);
		check(d, 32'h0000_0034);
	endtask

	// internal loop: refused write, lock, averaging, unlock, open again
	task automatic t_int_loop();
		logic [31:0] d;
		logic [11:0] f;
		bus_wr(8'h00, 32'h0000_0075);
		repeat (2) @(posedge clk_i);
		check(clock_mode_status_o, 2'h1);
		check(int_ref_sel_o & loop_closed_o, 1'b1);
		check({mult_factor_o, out_div_o}, 6'h2b);
		bus_wr(8'h08, 32'h0000_0001);
		check(filter_value_o, 12'h634);
		repeat (4) partner_u.send_sample(12'sd0);
		bus_rd(8'h04, d);
		check(d[2], 1'b1);
		repeat (3) partner_u.send_sample(12'sd4);
		check(filter_value_o, 12'h634);
		partner_u.send_sample(12'sd4);
		check(filter_value_o, 12'h630);
		partner_u.send_sample(12'sd20);
		bus_rd(8'h04, d);
		check(d[2], 1'b0);
		f = filter_value_o;
		bus_wr(8'h00, 32'h0000_0074);
		repeat (2) @(posedge clk_i);
		check(clock_mode_status_o, 2'h0);
		check(filter_value_o, f);
		check(loop_closed_o, 1'b0);
	endtask

	// stop plain, with debug, with generators kept running
	task automatic t_stop();
		logic [31:0] d;
		logic [11:0] f;
		f = filter_value_o;
		stop_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({out_clk_en_o, osc_run_o}, 2'b00);
		bus_rd(8'h04, d);
		check(d[3], 1'b0);
		stop_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check(out_clk_en_o, 1'b1);
		check(filter_value_o, f);
		debug_en_i <= 1'b1;
		stop_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({out_clk_en_o, osc_run_o}, 2'b11);
		stop_i <= 1'b0;
		debug_en_i <= 1'b0;
		bus_wr(8'h00, 32'h0000_0174);
		stop_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({out_clk_en_o, osc_run_o}, 2'b01);
		stop_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// wake with 01 selected waits for a stable, non-static oscillator
	task automatic t_off_exit();
		logic [31:0] d;
		bus_wr(8'h00, 32'h0000_0075);
		stop_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		stop_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check(clock_mode_status_o, 2'h0);
		partner_u.set_static(1'b1);
		repeat (3) @(posedge clk_i);
		repeat (2) partner_u.send_sample(12'sd0);
		bus_rd(8'h04, d);
		check(d[3:0], 4'h0);
		partner_u.set_static(1'b0);
		repeat (3) @(posedge clk_i);
		repeat (2) partner_u.send_sample(12'sd0);
		repeat (4) @(posedge clk_i);
		check(clock_mode_status_o, 2'h1);
	endtask

	// bypass: wake waits for the reference, loss falls back to self-clocked
	task automatic t_bypass();
		bus_wr(8'h00, 32'h0000_0074);
		partner_u.set_ref(1'b1, 1'b0);
		repeat (4) @(posedge clk_i);
		bus_wr(8'h00, 32'h0000_0076);
		repeat (2) @(posedge clk_i);
		check(clock_mode_status_o, 2'h2);
		stop_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		partner_u.set_ref(1'b0, 1'b0);
		stop_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check(out_clk_en_o, 1'b0);
		partner_u.set_ref(1'b1, 1'b0);
		repeat (4) @(posedge clk_i);
		check(out_clk_en_o, 1'b1);
		partner_u.set_ref(1'b0, 1'b1);
		repeat (4) @(posedge clk_i);
		check(clock_mode_status_o, 2'h0);
	endtask

	// external loop on a crystal: internal ref until ready, halved output until locked
	task automatic t_fee();
		partner_u.set_ref(1'b1, 1'b0);
		repeat (4) @(posedge clk_i);
		bus_wr(8'h00, 32'h0000_0277);
		check(clock_mode_status_o, 2'h3);
		check({out_half_o, int_ref_sel_o}, 2'b11);
		repeat (40) @(posedge clk_i);
		check(int_ref_sel_o, 1'b0);
		repeat (4) partner_u.send_sample(12'sd0);
		@(posedge clk_i);
		check({clock_mode_status_o, out_half_o}, 3'b110);
		partner_u.set_ref(1'b0, 1'b1);
		repeat (4) @(posedge clk_i);
		check(clock_mode_status_o, 2'h0);
	endtask

	// trim survives a reset that ends stop; the rest returns to defaults
	task automatic t_reset_trim();
		logic [31:0] d;
		bus_wr(8'h10, 32'h0000_005A);
		check(trim_o, 8'h5a);
		stop_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b1;
		stop_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus_rd(8'h10, d);
		check(d, 32'h0000_005A);
		check(filter_value_o, 12'h200);
		bus_rd(8'h00, d);
		check(d[1:0], 2'h0);
		por_i <= 1'b1;
		@(posedge clk_i);
		por_i <= 1'b0;
		@(posedge clk_i);
		check(trim_o, 8'h80);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// reset, then the scenarios in order
	initial begin
		err_count = 0;
		n_checks = 0;
		cyc = 0;
		rst_i = 1'b1;
		por_i = 1'b1;
		address_i = 8'h00;
		read_i = 1'b0;
		write_i = 1'b0;
		writedata_i = 32'h0000_0000;
		stop_i = 1'b0;
		debug_en_i = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		@(posedge clk_i);
		t_reset_values();
		t_filter_write();
		t_int_loop();
		t_stop();
		t_off_exit();
		t_bypass();
		t_fee();
		t_reset_trim();
		conclude();
	end
endmodule

`default_nettype wire
